// [rsi_cpu_model.sv]
// cpu side partner: acknowledges interrupt entry and resolves the reset pin
module rsi_cpu_model (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // interrupt handshake
  input  wire logic int_entry,
  input  wire logic slow,
  output logic      int_ack,
  // reset pin, pulled up on the board
  input  wire logic rst_pin_out,
  input  wire logic rst_pin_oe_n,
  input  wire logic ext_low,
  output logic      rst_pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_cnt;
  // open drain: either party pulls low, the pull-up wins otherwise
  assign rst_pin_in = ~ext_low & (rst_pin_oe_n | rst_pin_out);
  // stacking takes a few cycles, longer when slow
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_cnt <= 4'h0;
      int_ack  <= 1'b0;
    end else begin
      int_ack <= 1'b0;
      if (!int_entry || int_ack) begin
        wait_cnt <= 4'h0;
      end else if (wait_cnt == (slow ? 4'hA : 4'h2)) begin
        int_ack <= 1'b1;
      end else begin
        wait_cnt <= wait_cnt + 4'h1;
      end
    end
  end
endmodule // rsi_cpu_model

// [rsi_dly_cnt.sv]
// loadable down counter timing the reset sequence phases
module rsi_dly_cnt #(
  parameter int unsigned W = 13
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // control
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  input  wire logic [W-1:0] rst_val,
  // status
  output logic              zero
);
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  logic         first_reg;

  // the reset cycle counts as the first cycle of the power-on delay
  // saturates at zero so a phase never wraps into a second pass
  assign cnt_next = first_reg ? rst_val - 1'b1 :
                    load ? load_val : (cnt_reg == '0) ? cnt_reg : cnt_reg - 1'b1;
  assign zero     = (cnt_reg == '0) & ~first_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg   <= '0;
      first_reg <= 1'b1;
    end else begin
      cnt_reg   <= cnt_next;
      first_reg <= 1'b0;
    end
  end
endmodule // rsi_dly_cnt

// [rsi_int_arb.sv]
// fixed priority encoder over the peripheral requests, lowest number wins
module rsi_int_arb #(
  parameter int unsigned N = 16
) (
  // requests, bit i has priority i
  input  wire logic [N:1] req,
  // result
  output logic            any,
  output logic [4:0]      prio
);
  import rsi_pkg::*;

  always_comb begin
    any  = 1'b0;
    prio = 5'h00;
    for (int i = N; i >= 1; i--) begin
      if (req[i] && (i != PRIO_RSVD)) begin
        any  = 1'b1;
        prio = 5'(i);
      end
    end
  end
endmodule // rsi_int_arb

// [rsi_pkg.sv]
// constants, state codes and vector table of the reset and interrupt unit
package rsi_pkg;
  // register map, byte addresses on the apb
  localparam logic [11:0] OFS_CAUSE = 12'h000;
  localparam logic [11:0] OFS_CTRL  = 12'h004;
  localparam logic [11:0] OFS_SEQ   = 12'h008;
  // reset cause flag positions
  localparam int unsigned CB_POR  = 0;
  localparam int unsigned CB_PIN  = 1;
  localparam int unsigned CB_WDOG = 2;
  localparam int unsigned CB_BAD_OPCODE_FLAG = 3;
  localparam int unsigned CB_BAD_FETCH_ADDR_FLAG = 4;
  localparam int unsigned CB_LVI  = 5;
  localparam logic [7:0]  CAUSE_POR = 8'h01;
  // control register fields and reset value
  localparam int unsigned CTL_STOP_OK = 0;
  localparam int unsigned CTL_WD_EN   = 1;
  localparam logic [7:0]  CTRL_RST    = 8'h02;
  // sequencer timing, in oscillator clock cycles, and counter widths in bits
  localparam int unsigned OSC_DELAY_CYC = 4096;
  localparam int unsigned PIN_LOW_CYC   = 32;
  localparam int unsigned HOLD_CYC      = 32;
  localparam int unsigned EXT_MIN_CYC   = 4;
  localparam int unsigned CNT_W         = 13;
  localparam int unsigned WD_W          = 18;
  // vectors and special addresses
  localparam logic [15:0] RST_VEC     = 16'hFFFE;
  localparam logic [15:0] SWI_VEC     = 16'hFFFC;
  localparam logic [15:0] WD_CLR_ADDR = 16'hFFFF;
  localparam int unsigned IRQ_N       = 16;
  localparam int unsigned PRIO_RSVD   = 7;

  typedef enum logic [2:0] {
    ST_RUN    = 3'b000,
    ST_SUPPLY = 3'b001,
    ST_OSC    = 3'b010,
    ST_PIN    = 3'b011,
    ST_HOLD   = 3'b100,
    ST_EXT    = 3'b101
  } rsi_state_e;

  function automatic logic [15:0] rsi_vec_of(input logic [4:0] prio);
    logic [15:0] v;
    v = RST_VEC;
    case (prio)
      5'h01: v = 16'hFFFA;
      5'h02: v = 16'hFFF8;
      5'h03: v = 16'hFFF6;
      5'h04: v = 16'hFFF4;
      5'h05: v = 16'hFFF2;
      5'h06: v = 16'hFFF0;
      5'h08: v = 16'hFFEC;
      5'h09: v = 16'hFFEA;
      5'h0A: v = 16'hFFE8;
      5'h0B: v = 16'hFFE6;
      5'h0C: v = 16'hFFE4;
      5'h0D: v = 16'hFFE2;
      5'h0E: v = 16'hFFDE;
      5'h0F: v = 16'hFFDE;
      5'h10: v = 16'hFFDC;
      default: v = RST_VEC;
    endcase
    return v;
  endfunction
endpackage

// [rsi_top.sv]
// reset sequencing, reset cause register and interrupt arbitration
// What this block does
// - any reset aborts, reinitialises, fetches vector FFFE and picks bus clock div four
// - reset pin low for the minimum time causes external reset, sets pin flag
// - internal resets drive pin low 32 cycles, then hold chip 32 more
// - power-on gates clocks 4096 cycles with pin low, then 32 and 32 more
// - power-on sets power-on flag and clears all other cause flags
// - low supply holds pin low until recovery plus 4096, then 32/32, sets flag
// - watchdog overflow performs internal reset and sets watchdog flag
// - any write to address FFFF clears the watchdog counter
// - undefined opcode causes internal reset and sets bad opcode flag
// - stop instruction with stop not allowed counts as bad opcode
// - opcode fetch from unmapped address resets and sets bad fetch flag
// - data access to unmapped address causes no reset
// - cause register is read only and cleared only by reading it or by power-on
// - cause flags accumulate across resets until read
// - pin sampled 32 cycles after internal release, low sets pin flag
// - interrupts enter only at instruction boundaries
// - entry stacks registers, sets global mask, loads vector; return restores
// - a latched interrupt is never pre-empted during its entry
// - entry does not stack the index register high byte
// - after each instruction, with mask clear, highest pending request wins
// - priorities one to sixteen, seven reserved, with their fixed vectors
// - global mask blocks all but soft trap; priority zero is highest
// - soft trap is non-maskable and pushes pc rather than pc minus one
module rsi_top
  import rsi_pkg::*;
#(
  parameter int unsigned OSC_DELAY = rsi_pkg::OSC_DELAY_CYC,
  parameter int unsigned EXT_MIN   = rsi_pkg::EXT_MIN_CYC,
  parameter int unsigned WDW       = rsi_pkg::WD_W
) (
  // clock and power-on reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // reset sources
  input  wire logic        por_req,
  input  wire logic        low_supply,
  input  wire logic        bad_opcode,
  input  wire logic        stop_exec,
  input  wire logic        fetch_valid,
  input  wire logic        fetch_opcode,
  input  wire logic        fetch_mapped,
  input  wire logic        cpu_wr,
  input  wire logic [15:0] cpu_waddr,
  input  wire logic        clk_fast_sel,
  // open-drain reset pin
  input  wire logic        rst_pin_in,
  output logic             rst_pin_out,
  output logic             rst_pin_oe_n,
  // cpu reset side
  output logic             cpu_reset,
  output logic             clk_gate,
  output logic             bus_div4,
  output logic             vec_load,
  output logic      [15:0] cpu_vector,
  // interrupt side
  input  wire logic [16:1] irq_req,
  input  wire logic        instr_done,
  input  wire logic        i_mask,
  input  wire logic        swi_exec,
  input  wire logic        int_ack,
  output logic             int_entry,
  output logic             int_push_pcm1,
  output logic             int_set_imask
);
  import rsi_pkg::*;

  rsi_state_e   st_reg, st_next;
  logic [7:0]   cause_reg, cause_next, cause_set, rd_clr;
  logic [7:0]   ctrl_reg;
  logic [31:0]  prdata_reg, prdata_next, rd_mux;
  logic         pready_reg, pslverr_reg;
  logic [WDW-1:0] wd_cnt_reg, wd_cnt_next;
  logic [3:0]   ext_cnt_reg, ext_cnt_next;
  logic         internal_reg;
  logic         oe_n_reg, out_reg, cpu_rst_reg, gate_reg, div4_reg, vload_reg;
  logic [15:0]  vec_reg, vec_next;
  logic         ient_reg, pcm1_reg, simask_reg;
  logic [CNT_W-1:0] ld_val, len_reg;
  logic         dly_zero;

  // apb decode
  wire setup      = psel & ~penable;
  wire acc        = psel & penable & pready_reg;
  wire sel_cause  = (paddr == OFS_CAUSE);
  wire sel_ctrl   = (paddr == OFS_CTRL);
  wire sel_seq    = (paddr == OFS_SEQ);
  wire mapped     = sel_cause | sel_ctrl | sel_seq;
  wire rd_cause   = acc & ~pwrite & sel_cause;
  wire wr_ctrl    = acc & pwrite & sel_ctrl;

  // reset sources, only while the cpu runs except low supply and power-on
  wire running    = (st_reg == ST_RUN);
  wire wd_clr     = cpu_rst_reg | ~ctrl_reg[CTL_WD_EN]
                  | (cpu_wr & (cpu_waddr == WD_CLR_ADDR));
  wire wd_ovf     = running & (&wd_cnt_reg) & ~wd_clr;
  wire src_bad_opcode_flag   = running & (bad_opcode
                  | (stop_exec & ~ctrl_reg[CTL_STOP_OK]));
  // a data fetch never qualifies, only an opcode fetch
  wire src_bad_fetch_addr_flag   = running & fetch_valid & fetch_opcode & ~fetch_mapped;
  wire int_src    = wd_ovf | src_bad_opcode_flag | src_bad_fetch_addr_flag;
  wire ext_trig   = running & ~rst_pin_in
                  & (ext_cnt_reg == 4'(EXT_MIN - 1));
  wire lvi_enter  = low_supply & (st_reg != ST_SUPPLY);
  wire hold_done  = (st_reg == ST_HOLD) & dly_zero & ~por_req & ~lvi_enter;
  wire pin_late   = hold_done & internal_reg & ~rst_pin_in;
  wire st_chg     = (st_next != st_reg);
  wire drive_pin  = (st_next == ST_SUPPLY) | (st_next == ST_OSC) | (st_next == ST_PIN);

  // interrupt arbitration
  logic       req_any;
  logic [4:0] req_prio;

  rsi_int_arb #(
    .N (IRQ_N)
  ) rsi_int_arb_i (
    .req  (irq_req),
    .any  (req_any),
    .prio (req_prio)
  );

  // only taken at a boundary and only while nothing is latched
  wire int_take   = instr_done & ~ient_reg & ~cpu_rst_reg
                  & (swi_exec | (~i_mask & req_any));
  wire int_done   = ient_reg & int_ack & ~cpu_rst_reg;

  rsi_dly_cnt #(
    .W (CNT_W)
  ) rsi_dly_cnt_i (
    .pclk     (pclk),
    .presetn  (presetn),
    .load     (st_chg),
    .load_val (ld_val),
    .rst_val  (CNT_W'(OSC_DELAY - 1)),
    .zero     (dly_zero)
  );

  // reset sequencer
  always_comb begin
    st_next = st_reg;
    if (por_req) begin
      st_next = ST_OSC;
    end else if (lvi_enter) begin
      st_next = ST_SUPPLY;
    end else begin
      unique case (st_reg)
        ST_RUN: begin
          if (int_src) begin
            st_next = ST_PIN;
          end else if (ext_trig) begin
            st_next = ST_EXT;
          end
        end
        ST_SUPPLY: begin
          if (!low_supply) begin
            st_next = ST_OSC;
          end
        end
        ST_OSC: begin
          if (dly_zero) begin
            st_next = ST_PIN;
          end
        end
        ST_PIN: begin
          if (dly_zero) begin
            st_next = ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (dly_zero) begin
            st_next = ST_RUN;
          end
        end
        ST_EXT: begin
          if (rst_pin_in) begin
            st_next = ST_HOLD;
          end
        end
        default: st_next = ST_OSC;
      endcase
    end
  end

  assign ld_val = (st_next == ST_OSC)  ? CNT_W'(OSC_DELAY - 1) :
                  (st_next == ST_PIN)  ? CNT_W'(PIN_LOW_CYC - 1) :
                  (st_next == ST_HOLD) ? CNT_W'(HOLD_CYC - 1) : '0;

  // cause register: set wins over the read clear, and only bits that were read are cleared
  assign cause_set = (8'(ext_trig | pin_late) << CB_PIN)
                   | (8'(wd_ovf) << CB_WDOG)
                   | (8'(src_bad_opcode_flag) << CB_BAD_OPCODE_FLAG)
                   | (8'(src_bad_fetch_addr_flag) << CB_BAD_FETCH_ADDR_FLAG)
                   | (8'(lvi_enter) << CB_LVI);
  assign rd_clr     = rd_cause ? prdata_reg[7:0] : 8'h00;
  assign cause_next = por_req ? CAUSE_POR
                    : (cause_reg & ~rd_clr) | cause_set;

  // apb read path, data captured in the setup phase
  assign rd_mux = sel_cause ? {24'h000000, cause_reg} :
                  sel_ctrl  ? {24'h000000, ctrl_reg} :
                  sel_seq   ? {25'h0000000, st_reg, cpu_rst_reg, gate_reg, rst_pin_in, ient_reg} :
                  32'h00000000;
  assign prdata_next = setup ? rd_mux : prdata_reg;

  assign wd_cnt_next  = wd_clr ? '0 : wd_cnt_reg + 1'b1;
  assign ext_cnt_next = (running & ~rst_pin_in & ~ext_trig) ? ext_cnt_reg + 1'b1 : 4'h0;
  // the reset vector has priority over any interrupt vector
  assign vec_next = (st_chg & (st_next == ST_RUN)) ? RST_VEC :
                    int_take ? (swi_exec ? SWI_VEC : rsi_vec_of(req_prio)) :
                    vec_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg       <= ST_OSC;
      cause_reg    <= CAUSE_POR;
      ctrl_reg     <= CTRL_RST;
      prdata_reg   <= 32'h00000000;
      pready_reg   <= 1'b0;
      pslverr_reg  <= 1'b0;
      wd_cnt_reg   <= '0;
      ext_cnt_reg  <= 4'h0;
      internal_reg <= 1'b1;
      len_reg      <= '0;
    end else begin
      st_reg       <= st_next;
      cause_reg    <= cause_next;
      prdata_reg   <= prdata_next;
      pready_reg   <= setup;
      pslverr_reg  <= setup & ~mapped;
      wd_cnt_reg   <= wd_cnt_next;
      ext_cnt_reg  <= ext_cnt_next;
      len_reg      <= st_chg ? '0 : len_reg + 1'b1;
      if (wr_ctrl) begin
        ctrl_reg <= pwdata[7:0];
      end
      if (st_chg && (st_next == ST_PIN || st_next == ST_OSC)) begin
        internal_reg <= 1'b1;
      end else if (st_chg && st_next == ST_EXT) begin
        internal_reg <= 1'b0;
      end
    end
  end

  // pin and cpu reset outputs; the pin output value is always low, the enable does the work
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oe_n_reg    <= 1'b0;
      out_reg     <= 1'b0;
      cpu_rst_reg <= 1'b1;
      gate_reg    <= 1'b1;
      div4_reg    <= 1'b1;
      vload_reg   <= 1'b0;
      vec_reg     <= RST_VEC;
    end else begin
      oe_n_reg    <= ~drive_pin;
      out_reg     <= 1'b0;
      cpu_rst_reg <= (st_next != ST_RUN);
      gate_reg    <= (st_next == ST_SUPPLY) | (st_next == ST_OSC);
      div4_reg    <= (st_next != ST_RUN) | (div4_reg & ~clk_fast_sel);
      vload_reg   <= (st_chg & (st_next == ST_RUN)) | int_take;
      vec_reg     <= vec_next;
    end
  end

  // interrupt entry handshake; the cpu stacks pc, x, a, ccr but never the index high byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ient_reg   <= 1'b0;
      pcm1_reg   <= 1'b0;
      simask_reg <= 1'b0;
    end else begin
      // a reset abandons a latched entry
      ient_reg   <= ~cpu_rst_reg & (int_take | (ient_reg & ~int_ack));
      pcm1_reg   <= int_take ? ~swi_exec : pcm1_reg;
      simask_reg <= int_done;
    end
  end

  assign prdata        = prdata_reg;
  assign pready        = pready_reg;
  assign pslverr       = pslverr_reg;
  assign rst_pin_out   = out_reg;
  assign rst_pin_oe_n  = oe_n_reg;
  assign cpu_reset     = cpu_rst_reg;
  assign clk_gate      = gate_reg;
  assign bus_div4      = div4_reg;
  assign vec_load      = vload_reg;
  assign cpu_vector    = vec_reg;
  assign int_entry     = ient_reg;
  assign int_push_pcm1 = pcm1_reg;
  assign int_set_imask = simask_reg;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence leave_pin_s;
    (st_reg == ST_PIN) ##1 (st_reg == ST_HOLD);
  endsequence
  sequence leave_hold_s;
    (st_reg == ST_HOLD) ##1 (st_reg == ST_RUN);
  endsequence

  pin_phase_a: assert property (leave_pin_s |-> $past(len_reg) == CNT_W'(PIN_LOW_CYC - 1))
    else $error("reset pin phase length wrong");
  hold_phase_a: assert property (leave_hold_s |-> $past(len_reg) == CNT_W'(HOLD_CYC - 1))
    else $error("hold phase length wrong");
  osc_delay_a: assert property ((st_reg == ST_OSC) ##1 (st_reg == ST_PIN)
    |-> $past(len_reg) == CNT_W'(OSC_DELAY - 1) && !rst_pin_oe_n)
    else $error("oscillator delay length wrong");
  vec_fetch_a: assert property ($fell(cpu_reset) |-> vec_load && cpu_vector == RST_VEC && bus_div4)
    else $error("reset release without vector fetch");
  por_only_a: assert property (por_req |=> cause_reg == CAUSE_POR)
    else $error("power-on did not leave only its flag");
  cause_keep_a: assert property (!rd_cause && !por_req |=> (cause_reg & $past(cause_reg)) == $past(cause_reg))
    else $error("cause flag lost without read");
  wdog_rst_a: assert property (wd_ovf |=> cause_reg[CB_WDOG] && st_reg == ST_PIN ##1 !rst_pin_oe_n)
    else $error("watchdog overflow not reset");
  data_fetch_a: assert property (running && fetch_valid && !fetch_opcode && !bad_opcode && !stop_exec
    && !wd_ovf && !por_req && !low_supply && !ext_trig |=> st_reg == ST_RUN)
    else $error("data access caused reset");
  int_hold_a: assert property (int_entry && !int_ack && !cpu_reset |=> int_entry && $stable(cpu_vector))
    else $error("latched entry pre-empted");
  int_bound_a: assert property ($rose(int_entry) |-> $past(instr_done) && $past(swi_exec || !i_mask))
    else $error("entry off boundary or masked");
  swi_pc_a: assert property ($rose(int_entry) && $past(swi_exec) |-> !int_push_pcm1 && cpu_vector == SWI_VEC)
    else $error("soft trap pushed pc minus one");
endmodule // rsi_top

// [rsi_top_test.sv]
// self-checking testbench of the reset and interrupt unit
module rsi_top_test;
  import rsi_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        por_req = 1'b0, low_supply = 1'b0, bad_opcode = 1'b0, stop_exec = 1'b0;
  logic        fetch_valid = 1'b0, fetch_opcode = 1'b0, cpu_wr = 1'b0, clk_fast_sel = 1'b0;
  logic        instr_done = 1'b0, i_mask = 1'b0, swi_exec = 1'b0, ext_low = 1'b0, slow = 1'b0;
  logic [16:1] irq_req = 16'h0;
  logic        pready, pslverr, rst_pin_in, rst_pin_out, rst_pin_oe_n, cpu_reset, clk_gate;
  logic        bus_div4, vec_load, int_entry, int_push_pcm1, int_set_imask, int_ack;
  logic [15:0] cpu_vector;
  logic [5:0]  kick_cnt = 6'h0;
  logic [15:0] cpu_waddr = WD_CLR_ADDR;
  int          error_cnt = 0, cmp_count = 0;
  logic [15:0] vt [1:16] = '{16'hFFFA, 16'hFFF8, 16'hFFF6, 16'hFFF4, 16'hFFF2, 16'hFFF0,
                             16'h0000, 16'hFFEC, 16'hFFEA, 16'hFFE8, 16'hFFE6, 16'hFFE4,
                             16'hFFE2, 16'hFFDE, 16'hFFDE, 16'hFFDC};

  always #12.5 pclk = ~pclk;

  rsi_top #(.OSC_DELAY(64), .EXT_MIN(4), .WDW(10)) rsi_top_i (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .por_req, .low_supply, .bad_opcode, .stop_exec, .fetch_valid, .fetch_opcode,
    .fetch_mapped(1'b0), .cpu_wr, .cpu_waddr, .clk_fast_sel, .rst_pin_in,
    .rst_pin_out, .rst_pin_oe_n, .cpu_reset, .clk_gate, .bus_div4, .vec_load, .cpu_vector,
    .irq_req, .instr_done, .i_mask, .swi_exec, .int_ack, .int_entry, .int_push_pcm1,
    .int_set_imask);

  rsi_cpu_model rsi_cpu_model_i (.pclk, .presetn, .int_entry, .slow, .int_ack, .rst_pin_out,
    .rst_pin_oe_n, .ext_low, .rst_pin_in);

  // the cpu writes to cpu_waddr every 64 cycles; only the clear address feeds the watchdog
  always @(posedge pclk) begin
    kick_cnt <= kick_cnt + 6'h1;
    cpu_wr   <= (kick_cnt == 6'h0);
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      error_cnt++;
    end
  endtask

  // apb transfer; answer taken and request released at the edge where pready is high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] exp, input logic experr);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 50) error_cnt++;
    if (!w) chk(prdata, exp);
    chk(pslverr, experr);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // stray cpu writes elsewhere must not keep the watchdog quiet
  task automatic wdog();
    int n;
    n = 0;
    @(posedge pclk);
    cpu_waddr <= 16'hFFFE;
    @(negedge pclk);
    while (cpu_reset === 1'b0 && n < 1100) begin
      n++;
      @(negedge pclk);
    end
    chk(cpu_reset, 1'b1);
    @(posedge pclk);
    cpu_waddr <= WD_CLR_ADDR;
    // one pin-low cycle was spent detecting the reset
    seq(31, 32);
  endtask

  // counts pin-low cycles, then held-in-reset cycles, then checks the restart
  task automatic seq(input int lo, input int hold);
    int n;
    int m;
    n = 0;
    m = 0;
    @(negedge pclk);
    while (rst_pin_oe_n === 1'b0 && n < 5000) begin
      n++;
      @(negedge pclk);
    end
    while (cpu_reset === 1'b1 && m < 5000) begin
      m++;
      @(negedge pclk);
    end
    chk(n, lo);
    chk(m, hold);
    chk({vec_load, bus_div4, cpu_vector}, {2'b11, RST_VEC});
  endtask

  // one-cycle source strobe: 0 bad opcode, 1 stop, 2 data fetch, 3 opcode fetch
  task automatic hit(input int k, input logic rst);
    @(posedge pclk);
    case (k)
      0: bad_opcode <= 1'b1;
      1: stop_exec <= 1'b1;
      2: fetch_valid <= 1'b1;
      default: {fetch_valid, fetch_opcode} <= 2'b11;
    endcase
    @(posedge pclk);
    {bad_opcode, stop_exec, fetch_valid, fetch_opcode} <= 4'h0;
    if (rst) begin
      seq(32, 32);
    end else begin
      repeat (4) @(negedge pclk);
      chk(cpu_reset, 1'b0);
    end
  endtask

  task automatic fire(input logic [16:1] r, input logic im, input logic sw, input logic done,
                      input logic [15:0] v, input logic pc);
    int n;
    n = 0;
    @(posedge pclk);
    {irq_req, i_mask, swi_exec, instr_done} <= {r, im, sw, done};
    @(posedge pclk);
    {swi_exec, instr_done} <= 2'b00;
    @(negedge pclk);
    if (v == 16'h0) begin
      repeat (3) @(negedge pclk);
      chk(int_entry, 1'b0);
    end else begin
      chk({int_entry, vec_load, cpu_vector, int_push_pcm1}, {2'b11, v, pc});
      @(posedge pclk);
      {irq_req, i_mask, instr_done} <= {16'h0001, 2'b01};
      @(posedge pclk);
      instr_done <= 1'b0;
      @(negedge pclk);
      chk(cpu_vector, v);
      while (int_entry === 1'b1 && n < 30) begin
        @(negedge pclk);
        n++;
      end
      chk(int_set_imask, 1'b1);
    end
    @(posedge pclk);
    irq_req <= 16'h0;
  endtask

  task automatic end_of_test;
    $display("comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge pclk);
    error_cnt++;
    end_of_test();
  end

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    seq(96, 32);
    clk_fast_sel <= 1'b1;
    @(posedge pclk);
    clk_fast_sel <= 1'b0;
    @(negedge pclk);
    chk(bus_div4, 1'b0);
    apb(0, OFS_CAUSE, 0, 32'h01, 0);
    apb(1, OFS_CAUSE, 32'hFF, 0, 0);
    apb(0, OFS_CAUSE, 0, 32'h00, 0);
    apb(0, OFS_CTRL, 0, 32'h02, 0);
    apb(0, 12'h00C, 0, 32'h00, 1);
    hit(0, 1);
    hit(2, 0);
    hit(3, 1);
    hit(1, 1);
    apb(0, OFS_CAUSE, 0, 32'h18, 0);
    apb(1, OFS_CTRL, 32'h03, 0, 0);
    hit(1, 0);
    apb(1, OFS_CTRL, 32'h02, 0, 0);
    apb(0, OFS_CAUSE, 0, 32'h00, 0);
    @(posedge pclk);
    ext_low <= 1'b1;
    repeat (2) @(posedge pclk);
    ext_low <= 1'b0;
    repeat (4) @(negedge pclk);
    chk(cpu_reset, 1'b0);
    @(posedge pclk);
    ext_low <= 1'b1;
    repeat (8) @(posedge pclk);
    ext_low <= 1'b0;
    @(posedge pclk);
    seq(0, 32);
    apb(0, OFS_CAUSE, 0, 32'h02, 0);
    @(posedge pclk);
    low_supply <= 1'b1;
    repeat (10) @(negedge pclk);
    chk({rst_pin_oe_n, clk_gate}, 2'b01);
    @(posedge pclk);
    low_supply <= 1'b0;
    @(posedge pclk);
    seq(96, 32);
    apb(0, OFS_CAUSE, 0, 32'h20, 0);
    repeat (1300) @(negedge pclk);
    chk(cpu_reset, 1'b0);
    wdog();
    apb(0, OFS_CAUSE, 0, 32'h04, 0);
    hit(0, 1);
    @(posedge pclk);
    por_req <= 1'b1;
    @(posedge pclk);
    por_req <= 1'b0;
    seq(96, 32);
    apb(0, OFS_CAUSE, 0, 32'h01, 0);
    for (int p = 1; p <= 16; p++) begin
      if (p != 7) fire((16'h3 << (p - 1)), 0, 0, 1, vt[p], 1);
    end
    fire(16'h0002, 0, 0, 0, 16'h0, 0);
    fire(16'h0002, 1, 0, 1, 16'h0, 0);
    slow <= 1'b1;
    fire(16'h0002, 1, 1, 1, SWI_VEC, 0);
    end_of_test();
  end
endmodule // rsi_top_test
